// [hw/lmf_front_end.sv]
`timescale 1ns/1ns
`include "lmf_params.svh"

module lmf_front_end import lmf_pkg::*; #(
	parameter logic [7:0]  FAMILY_CODE = 8'h5A, // arbitrary value
	parameter logic [47:0] SERIAL      = 48'h0123_4567_89AB, // arbitrary value
	parameter int          DELAY_CYCLES = `LMF_RTC_DELAY_MS * 1000 * `LMF_CLK_MHZ
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// bus-side reset and bit events
	input  wire logic        bus_reset,
	input  wire logic        rx_bit_valid,
	input  wire logic        rx_bit,
	input  wire logic        tx_bit_req,
	// bus power
	input  wire logic        bus_high,
	// decoded extended command and memory access
	input  wire lmf_xcmd_t   xcmd,
	input  wire lmf_mem_req_t mem_req,
	// device state
	input  wire logic        mission_programmed,
	input  wire logic        clear_done,
	// outputs
	output logic             tx_bit,
	output logic [7:0]       rx_byte,
	output logic             rx_byte_valid,
	output logic             overdrive,
	output logic             func_enabled,
	output logic             powered,
	output logic [63:0]      rom_id,
	output logic             crc_ok,
	output logic [7:0]       result_byte,
	output logic             delay_busy,
	output lmf_mem_rsp_t     mem_rsp,
	output logic [255:0]     scratchpad
);

	if (DELAY_CYCLES < 1) begin : g_bad_delay
		$error("delay must be at least one cycle");
	end

	//----------------------------------------
	// decoding helpers
	//----------------------------------------
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		crc_step = (c >> 1) ^ (fb ? `LMF_CRC_POLY : 8'h00);
	endfunction

	function automatic lmf_region_t region_of(input logic [16:0] a);
		if (a <= `LMF_GP_LAST)                          region_of = LMF_REG_GP;
		else if (a >= `LMF_PW_FIRST && a <= `LMF_PW_LAST) region_of = LMF_REG_PASSWORD;
		else if (a <= `LMF_REG2_LAST)                   region_of = LMF_REG_REGPAGE;
		else if (a <= `LMF_RSV1_LAST)                   region_of = LMF_REG_RESERVED;
		else if (a <= `LMF_BKP_LAST)                    region_of = LMF_REG_BACKUP;
		else if (a <= `LMF_RSV2_LAST)                   region_of = LMF_REG_RESERVED;
		else if (a <= `LMF_LOG_LAST)                    region_of = LMF_REG_LOG;
		else                                            region_of = LMF_REG_NONE;
	endfunction

	function automatic logic is_rtc_cmd(input logic [7:0] c);
		is_rtc_cmd = (c == `LMF_CMD_COPY) || (c == `LMF_CMD_FORCED) ||
			(c == `LMF_CMD_BEGIN) || (c == `LMF_CMD_BATTERY);
	endfunction

	function automatic logic is_rom_cmd(input logic [7:0] c);
		case (c)
			`LMF_ROM_READ, `LMF_ROM_MATCH, `LMF_ROM_SEARCH, `LMF_ROM_CSEARCH,
			`LMF_ROM_SKIP, `LMF_ROM_OD_SKIP, `LMF_ROM_OD_MATCH, `LMF_ROM_RESUME: is_rom_cmd = 1'b1;
			default: is_rom_cmd = 1'b0;
		endcase
	endfunction

	//----------------------------------------
	// id and crc
	//----------------------------------------
	logic [55:0] id_body;
	logic [7:0]  id_crc;
	assign id_body = {SERIAL, FAMILY_CODE};
	always_comb begin
		id_crc = `LMF_CRC_INIT;
		for (int i = 0; i < 56; i++)
			id_crc = crc_step(id_crc, id_body[i]);
	end

	//----------------------------------------
	// protocol state
	//----------------------------------------
	typedef enum logic [1:0] {ST_ROM, ST_FUNC, ST_RESULT} lmf_state_t;
	lmf_state_t  state, next_state;
	logic [7:0]  shreg, next_shreg;
	logic [2:0]  bitcnt, next_bitcnt;
	logic [7:0]  txsh, next_txsh;
	logic [2:0]  txcnt, next_txcnt;
	logic        next_overdrive, next_rx_byte_valid, next_tx_bit;
	logic [7:0]  next_rx_byte, next_result_byte;
	logic [7:0]  chk, next_chk;
	logic [6:0]  chk_cnt, next_chk_cnt;
	logic        next_crc_ok;
	logic        clr_state, next_clr_state;
	logic [31:0] dly, next_dly;
	logic [7:0]  pend, next_pend;
	logic        next_delay_busy;
	logic [7:0]  gp_written [0:63];
	logic [255:0] next_scratch;
	lmf_mem_rsp_t next_mem_rsp;
	logic        gp_set;
	logic [5:0]  gp_idx;
	logic [7:0]  byte_in;

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_txsh = txsh;
		next_txcnt = txcnt;
		next_overdrive = overdrive;
		next_rx_byte = rx_byte;
		next_rx_byte_valid = 1'b0;
		next_tx_bit = tx_bit;
		next_result_byte = result_byte;
		next_chk = chk;
		next_chk_cnt = chk_cnt;
		next_crc_ok = crc_ok;
		next_clr_state = clr_state;
		next_dly = dly;
		next_pend = pend;
		next_delay_busy = delay_busy;
		byte_in = {rx_bit, shreg[7:1]};
		if (bus_reset) begin
			next_state = ST_ROM;
			next_bitcnt = 3'h0;
			next_txcnt = 3'h0;
			next_chk = `LMF_CRC_INIT;
			next_chk_cnt = 7'h00;
		end else begin
			if (rx_bit_valid) begin
				next_shreg = byte_in;
				next_bitcnt = bitcnt + 3'h1;
				if (chk_cnt < 7'd64) begin
					next_chk = crc_step(chk, rx_bit);
					next_chk_cnt = chk_cnt + 7'h01;
					if (chk_cnt == 7'd63)
						next_crc_ok = (crc_step(chk, rx_bit) == 8'h00);
				end
				if (bitcnt == 3'h7) begin
					next_rx_byte = byte_in;
					next_rx_byte_valid = 1'b1;
					if (state == ST_ROM && is_rom_cmd(byte_in)) begin
						next_state = ST_FUNC;
						if (!overdrive && (byte_in == `LMF_ROM_OD_SKIP || byte_in == `LMF_ROM_OD_MATCH))
							next_overdrive = 1'b1;
					end
				end
			end
			if (tx_bit_req) begin
				next_tx_bit = (state == ST_RESULT) ? result_byte[txcnt] : txsh[0];
				next_txsh = {1'b1, txsh[7:1]};
				next_txcnt = txcnt + 3'h1;
			end
		end
		// a bus reset in the same cycle wins: the command is dropped
		if (xcmd.valid && state == ST_FUNC && !bus_reset) begin
			next_state = ST_RESULT;
			if (mission_programmed && xcmd.code == `LMF_CMD_BEGIN)
				next_result_byte = `LMF_RES_MISSION;
			else if (clr_state && is_rtc_cmd(xcmd.code)) begin
				next_result_byte = `LMF_RES_BUSY;
				next_pend = xcmd.outcome;
				next_dly = 32'(DELAY_CYCLES - 1);
				next_delay_busy = 1'b1;
				next_clr_state = 1'b0;
			end else
				next_result_byte = xcmd.outcome;
		end
		if (delay_busy) begin
			if (dly == 32'h0) begin
				next_delay_busy = 1'b0;
				next_result_byte = pend;
			end else
				next_dly = dly - 32'h1;
		end
		if (clear_done)
			next_clr_state = 1'b1;
	end

	//----------------------------------------
	// memory access decode
	//----------------------------------------
	assign gp_idx = mem_req.addr[8:3];
	always_comb begin
		next_mem_rsp = '0;
		next_scratch = scratchpad;
		gp_set = 1'b0;
		if (mem_req.valid) begin
			next_mem_rsp.valid = 1'b1;
			next_mem_rsp.region = region_of(mem_req.addr);
			next_mem_rsp.result = `LMF_RES_OK;
			next_mem_rsp.ok = 1'b1;
			case (region_of(mem_req.addr))
				LMF_REG_GP: begin
					if (mem_req.write && gp_written[gp_idx][mem_req.addr[2:0]]) begin
						next_mem_rsp.ok = 1'b0;
						next_mem_rsp.result = `LMF_RES_WRITE_ERR;
					end else if (mem_req.write)
						gp_set = 1'b1;
				end
				LMF_REG_REGPAGE, LMF_REG_PASSWORD: begin
					if (mem_req.write && mission_programmed) begin
						next_mem_rsp.ok = 1'b0;
						next_mem_rsp.result = `LMF_RES_MISSION;
					end
					next_mem_rsp.hide = !mem_req.write && region_of(mem_req.addr) == LMF_REG_PASSWORD;
				end
				LMF_REG_BACKUP, LMF_REG_LOG: begin
					if (mem_req.write) begin
						next_mem_rsp.ok = 1'b0;
						next_mem_rsp.result = `LMF_RES_BAD_PARAM;
					end
				end
				default: begin
					next_mem_rsp.ok = 1'b0;
					next_mem_rsp.result = `LMF_RES_BAD_PARAM;
				end
			endcase
			if (mem_req.write && next_mem_rsp.ok)
				next_scratch[{mem_req.addr[4:0], 3'b000} +: 8] = mem_req.wdata;
		end
	end

	//----------------------------------------
	// registers
	//----------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_ROM;
			shreg <= 8'h00;
			bitcnt <= 3'h0;
			txsh <= 8'hFF;
			txcnt <= 3'h0;
			overdrive <= 1'b0;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
			tx_bit <= 1'b1;
			result_byte <= `LMF_RES_BUSY;
			chk <= `LMF_CRC_INIT;
			chk_cnt <= 7'h00;
			crc_ok <= 1'b0;
			clr_state <= 1'b1;
			dly <= 32'h0;
			pend <= 8'h00;
			delay_busy <= 1'b0;
			mem_rsp <= '0;
			scratchpad <= '0;
			func_enabled <= 1'b0;
			powered <= 1'b0;
			rom_id <= 64'h0;
			for (int i = 0; i < 64; i++)
				gp_written[i] <= 8'h00;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			txsh <= next_txsh;
			txcnt <= next_txcnt;
			overdrive <= next_overdrive;
			rx_byte <= next_rx_byte;
			rx_byte_valid <= next_rx_byte_valid;
			tx_bit <= next_tx_bit;
			result_byte <= next_result_byte;
			chk <= next_chk;
			chk_cnt <= next_chk_cnt;
			crc_ok <= next_crc_ok;
			clr_state <= next_clr_state;
			dly <= next_dly;
			pend <= next_pend;
			delay_busy <= next_delay_busy;
			mem_rsp <= next_mem_rsp;
			scratchpad <= next_scratch;
			func_enabled <= (next_state != ST_ROM);
			powered <= bus_high;
			rom_id <= {id_crc, id_body};
			// clear wins here: an erase wipes the whole once-only record
			for (int i = 0; i < 64; i++)
				if (clear_done)
					gp_written[i] <= 8'h00;
				else if (gp_set && gp_idx == 6'(i))
					gp_written[i][mem_req.addr[2:0]] <= 1'b1;
		end
	end

endmodule

// [pkg/lmf_params.svh]
`ifndef LMF_PARAMS_SVH
`define LMF_PARAMS_SVH

// address map
`define LMF_GP_LAST        17'h001FF
`define LMF_REG1_FIRST     17'h00200
`define LMF_REG2_LAST      17'h0023F
`define LMF_RSV1_FIRST     17'h00240
`define LMF_RSV1_LAST      17'h0025F
`define LMF_BKP_FIRST      17'h00260
`define LMF_BKP_LAST       17'h0029F
`define LMF_RSV2_FIRST     17'h002A0
`define LMF_RSV2_LAST      17'h00FFF
`define LMF_LOG_FIRST      17'h01000
`define LMF_LOG_LAST       17'h1F9FF
`define LMF_PW_FIRST       17'h00228
`define LMF_PW_LAST        17'h00237

// crc
`define LMF_CRC_POLY       8'h8C
`define LMF_CRC_INIT       8'h00

// rom-level commands
`define LMF_ROM_READ       8'h33
`define LMF_ROM_MATCH      8'h55
`define LMF_ROM_SEARCH     8'hF0
`define LMF_ROM_CSEARCH    8'hEC
`define LMF_ROM_SKIP       8'hCC
`define LMF_ROM_OD_SKIP    8'h3C
`define LMF_ROM_OD_MATCH   8'h69
`define LMF_ROM_RESUME     8'hA5

// extended commands that may start the rtc
`define LMF_CMD_COPY       8'h99
`define LMF_CMD_FORCED     8'h4B
`define LMF_CMD_BEGIN      8'hDD
`define LMF_CMD_BATTERY    8'h33

// result bytes
`define LMF_RES_BUSY       8'hFF
`define LMF_RES_OK         8'hAA
`define LMF_RES_OK_ALT     8'h55
`define LMF_RES_MISSION    8'h22
`define LMF_RES_WRITE_ERR  8'h44
`define LMF_RES_BAD_PARAM  8'h77
`define LMF_RES_BAD_AUTH   8'h33
`define LMF_RES_BAD_PW     8'h11
`define LMF_RES_NEED_CLEAR 8'h00

// timing
`define LMF_RTC_DELAY_MS   500
`define LMF_CLK_MHZ        250

`endif

// [pkg/lmf_pkg.sv]
package lmf_pkg;

	typedef enum logic [3:0] {
		LMF_REG_NONE,
		LMF_REG_GP,
		LMF_REG_REGPAGE,
		LMF_REG_PASSWORD,
		LMF_REG_BACKUP,
		LMF_REG_RESERVED,
		LMF_REG_LOG
	} lmf_region_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [16:0] addr;
		logic [7:0]  wdata;
	} lmf_mem_req_t;

	typedef struct packed {
		logic        valid;
		logic        ok;
		logic        hide;
		lmf_region_t region;
		logic [7:0]  result;
	} lmf_mem_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] outcome;
	} lmf_xcmd_t;

endpackage

// [tb/lmf_fe_assertions.sv]
`timescale 1ns/1ns
module lmf_fe_assertions import lmf_pkg::*; #(
	parameter int DELAY_CYCLES = 10
) (
	// clock and reset
	input wire logic         core_clk,
	input wire logic         arst_n,
	// inputs
	input wire logic         bus_reset,
	input wire logic         bus_high,
	input wire lmf_xcmd_t    xcmd,
	input wire lmf_mem_req_t mem_req,
	input wire logic         mission_programmed,
	// outputs
	input wire logic         overdrive,
	input wire logic         func_enabled,
	input wire logic         powered,
	input wire logic [7:0]   result_byte,
	input wire logic         delay_busy,
	input wire lmf_mem_rsp_t mem_rsp
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic        wr;
	logic        rd;
	logic [16:0] a;
	logic        in_result;
	logic [31:0] busy_len;
	assign wr = mem_req.valid && mem_req.write;
	assign rd = mem_req.valid && !mem_req.write;
	assign a = mem_req.addr;
	// a taken command holds its answer until the next bus reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_result <= 1'b0;
			busy_len <= 32'h0;
		end else begin
			busy_len <= delay_busy ? busy_len + 32'h1 : 32'h0;
			if (bus_reset)
				in_result <= 1'b0;
			else if (xcmd.valid && func_enabled)
				in_result <= 1'b1;
		end
	end

	power_follow_a: assert property (bus_high |=> powered) else $error("powered lags bus");
	od_sticky_a: assert property (overdrive |=> overdrive) else $error("overdrive lost");
	gate_xcmd_a: assert property (xcmd.valid && (!func_enabled || in_result) && !delay_busy && !bus_reset
		|=> $stable(result_byte)) else $error("command taken before rom phase");
	result_hold_a: assert property (!xcmd.valid && !delay_busy && !bus_reset && !$fell(delay_busy)
		|=> $stable(result_byte)) else $error("result byte changed");
	result_next_a: assert property (xcmd.valid && func_enabled && !in_result && !mission_programmed
		&& !delay_busy && !bus_reset
		|=> result_byte == $past(xcmd.outcome) || result_byte == 8'hFF && delay_busy)
		else $error("result byte wrong");
	delay_len_a: assert property ($fell(delay_busy) |-> busy_len == 32'(DELAY_CYCLES))
		else $error("start delay length");
	mission_ref_a: assert property (wr && mission_programmed && a inside {[17'h00200:17'h0023F]}
		|=> mem_rsp.result == 8'h22 && !mem_rsp.ok) else $error("page write in mission");
	log_ro_a: assert property (wr && a inside {[17'h01000:17'h1F9FF]} |=> mem_rsp.valid && !mem_rsp.ok)
		else $error("log write accepted");
	pw_hide_a: assert property (rd && a inside {[17'h00228:17'h00237]}
		|=> mem_rsp.hide && mem_rsp.region == LMF_REG_PASSWORD) else $error("password shown");
	rsv_map_a: assert property (rd && a inside {[17'h00240:17'h0025F], [17'h002A0:17'h00FFF]}
		|=> mem_rsp.region == LMF_REG_RESERVED) else $error("reserved decode");
	gp_map_a: assert property (rd && a <= 17'h001FF |=> mem_rsp.valid && mem_rsp.region == LMF_REG_GP)
		else $error("general decode");
	bkp_ro_a: assert property (wr && a inside {[17'h00260:17'h0029F]} |=> !mem_rsp.ok)
		else $error("backup write accepted");

	cover property ($rose(delay_busy));
	cover property ($rose(overdrive));
	cover property (mem_rsp.valid && mem_rsp.result == 8'h44);
endmodule

bind lmf_front_end lmf_fe_assertions #(.DELAY_CYCLES(DELAY_CYCLES)) chk_u (.core_clk, .arst_n, .bus_reset,
	.bus_high, .xcmd, .mem_req, .mission_programmed, .overdrive, .func_enabled, .powered, .result_byte,
	.delay_busy, .mem_rsp);

// [tb/lmf_bus_master.sv]
`timescale 1ns/1ns
module lmf_bus_master (
	// clock
	input  wire logic core_clk,
	// device side
	input  wire logic tx_bit,
	output logic      bus_reset,
	output logic      rx_bit_valid,
	output logic      rx_bit,
	output logic      tx_bit_req
);
	initial begin
		bus_reset = 1'b0;
		rx_bit_valid = 1'b0;
		rx_bit = 1'b0;
		tx_bit_req = 1'b0;
	end
	// callers that need the function phase follow the reset with a rom-level command (see sel)
	task automatic reset_bus();
		@(negedge core_clk) bus_reset = 1'b1;
		@(negedge core_clk) bus_reset = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			rx_bit_valid = 1'b1;
			rx_bit = b[i];
		end
		@(negedge core_clk);
		rx_bit_valid = 1'b0;
		// idle line shows no stale bit
		rx_bit = ~rx_bit;
	endtask
	task automatic read_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			tx_bit_req = 1'b1;
			@(negedge core_clk);
			tx_bit_req = 1'b0;
			b[i] = tx_bit;
		end
	endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
	import lmf_pkg::*;
	// arbitrary identity values
	localparam logic [7:0]  FAM = 8'h5A;
	localparam logic [47:0] SER = 48'h0123_4567_89AB;
	localparam int          DLY = 10;
	logic         core_clk, arst_n, bus_reset, rx_bit_valid, rx_bit, tx_bit_req, bus_high, tx_bit;
	logic         mission_programmed, clear_done, rx_byte_valid, overdrive, func_enabled, powered, crc_ok;
	logic         delay_busy;
	logic [7:0]   rx_byte, result_byte, rb;
	logic [63:0]  rom_id, id;
	logic [255:0] scratchpad;
	lmf_xcmd_t    xcmd;
	lmf_mem_req_t mem_req;
	lmf_mem_rsp_t mem_rsp;
	int           miscompares = 0;
	int           n_compared = 0;

	lmf_front_end #(.FAMILY_CODE(FAM), .SERIAL(SER), .DELAY_CYCLES(DLY)) dut_u (.core_clk, .arst_n, .bus_reset,
		.rx_bit_valid, .rx_bit, .tx_bit_req, .bus_high, .xcmd, .mem_req, .mission_programmed, .clear_done,
		.tx_bit, .rx_byte, .rx_byte_valid, .overdrive, .func_enabled, .powered, .rom_id, .crc_ok,
		.result_byte, .delay_busy, .mem_rsp, .scratchpad);
	lmf_bus_master master_u (.core_clk, .tx_bit, .bus_reset, .rx_bit_valid, .rx_bit, .tx_bit_req);

	// ----
	// helpers
	// ----
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
		return c;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xc(input logic [7:0] c, input logic [7:0] o);
		@(negedge core_clk) xcmd = '{1'b1, c, o};
		@(negedge core_clk) xcmd.valid = 1'b0;
	endtask
	task automatic mem(input logic w, input logic [16:0] a, input logic [7:0] d);
		@(negedge core_clk) mem_req = '{1'b1, w, a, d};
		@(negedge core_clk) mem_req.valid = 1'b0;
	endtask
	task automatic clr();
		@(negedge core_clk) clear_done = 1'b1;
		@(negedge core_clk) clear_done = 1'b0;
	endtask
	// every command needs a fresh bus reset and rom-level command first
	task automatic sel();
		master_u.reset_bus();
		master_u.send_byte(8'hCC);
	endtask
	task automatic wait_res(input logic [7:0] o);
		int n;
		n = 0;
		while (result_byte === 8'hFF && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		chk(n, DLY);
		chk(result_byte, o);
		if (n == 50) end_of_test();
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_id();
		@(negedge core_clk) bus_high = 1'b0;
		@(negedge core_clk) chk(powered, 0);
		bus_high = 1'b1;
		@(negedge core_clk) chk(powered, 1);
		id = {crc8({SER, FAM}), SER, FAM};
		chk(rom_id, id);
		for (int p = 0; p < 2; p++) begin
			master_u.reset_bus();
			for (int i = 0; i < 8; i++) begin
				master_u.send_byte(id[8*i +: 8] ^ ((p == 1 && i == 7) ? 8'h10 : 8'h00));
				chk({rx_byte_valid, rx_byte}, {1'b1, id[8*i +: 8] ^ ((p == 1 && i == 7) ? 8'h10 : 8'h00)});
			end
			@(negedge core_clk) chk(crc_ok, p == 0);
		end
	endtask
	task automatic t_gate();
		logic [7:0] rc [8] = '{8'h33, 8'h55, 8'hF0, 8'hEC, 8'hCC, 8'hA5, 8'h3C, 8'h69};
		master_u.reset_bus();
		chk(func_enabled, 0);
		xc(8'h4B, 8'hAA);
		chk(result_byte, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			master_u.reset_bus();
			master_u.send_byte(rc[i]);
			chk(func_enabled, 1);
			chk(overdrive, i >= 6);
		end
	endtask
	task automatic t_mem();
		logic [16:0] ra [13] = '{17'h001FF, 17'h00200, 17'h0023F, 17'h00228, 17'h00237, 17'h00240, 17'h0025F,
			17'h00260, 17'h0029F, 17'h002A0, 17'h00FFF, 17'h01000, 17'h1F9FF};
		lmf_region_t rr [13] = '{LMF_REG_GP, LMF_REG_REGPAGE, LMF_REG_REGPAGE, LMF_REG_PASSWORD, LMF_REG_PASSWORD,
			LMF_REG_RESERVED, LMF_REG_RESERVED, LMF_REG_BACKUP, LMF_REG_BACKUP, LMF_REG_RESERVED,
			LMF_REG_RESERVED, LMF_REG_LOG, LMF_REG_LOG};
		mem(1, 17'h00005, 8'hC3);
		chk({mem_rsp.valid, mem_rsp.ok, mem_rsp.region}, {2'b11, LMF_REG_GP});
		chk(scratchpad[47:40], 8'hC3);
		mem(1, 17'h00005, 8'h3C);
		chk({mem_rsp.ok, mem_rsp.result}, {1'b0, 8'h44});
		clr();
		mem(1, 17'h00005, 8'h3C);
		chk(mem_rsp.ok, 1);
		for (int i = 0; i < 13; i++) begin
			mem(0, ra[i], 8'h00);
			chk({mem_rsp.valid, mem_rsp.region, mem_rsp.hide}, {1'b1, rr[i], rr[i] == LMF_REG_PASSWORD});
			if (i > 4) begin
				mem(1, ra[i], 8'hA5);
				chk({mem_rsp.ok, mem_rsp.result}, {1'b0, 8'h77});
			end
		end
		mem(1, 17'h00230, 8'h12);
		chk(mem_rsp.ok, 1);
	endtask
	task automatic t_delay();
		logic [7:0] dc [4] = '{8'h99, 8'h4B, 8'hDD, 8'h33};
		for (int i = 0; i < 4; i++) begin
			if (i > 0) clr();
			sel();
			xc(dc[i], 8'hAA);
			chk({delay_busy, result_byte}, {1'b1, 8'hFF});
			wait_res(8'hAA);
			sel();
			xc(dc[i], 8'h55);
			chk({delay_busy, result_byte}, {1'b0, 8'h55});
		end
		xc(8'h4B, 8'h77);
		chk(result_byte, 8'h55);
		repeat (2) begin
			master_u.read_byte(rb);
			chk(rb, 8'h55);
		end
		clr();
		sel();
		xc(8'hDD, 8'h44);
		chk(delay_busy, 1);
		wait_res(8'h44);
	endtask
	task automatic t_mission();
		@(negedge core_clk) mission_programmed = 1'b1;
		sel();
		xc(8'hDD, 8'hAA);
		chk(result_byte, 8'h22);
		mem(1, 17'h00210, 8'h01);
		chk({mem_rsp.ok, mem_rsp.result}, {1'b0, 8'h22});
		mem(1, 17'h0022A, 8'h01);
		chk({mem_rsp.ok, mem_rsp.result}, {1'b0, 8'h22});
		@(negedge core_clk) mission_programmed = 1'b0;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
	initial begin
		arst_n = 1'b0;
		bus_high = 1'b1;
		xcmd = '0;
		mem_req = '0;
		mission_programmed = 1'b0;
		clear_done = 1'b0;
		repeat (10) @(negedge core_clk);
		chk({tx_bit, result_byte}, {1'b1, 8'hFF});
		arst_n = 1'b1;
		t_id();
		t_gate();
		t_mem();
		t_delay();
		t_mission();
		end_of_test();
	end
endmodule
